// ### rtl/oss_pkg.sv
// Package for the output signal selector: register map, field layout,
// reset values, setting encodings and timing constants.
// Assumes a single 10 MHz clock shared by every user of the package.
package oss_pkg;

  localparam int CLK_HZ          = 10_000_000;
  localparam int BRAKE_DELAY_MS  = 500;
  localparam int BRAKE_DELAY_CYC = BRAKE_DELAY_MS * (CLK_HZ / 1000);

  // Register byte offsets
  localparam logic [7:0] ADDR_AOUT_CFG  = 8'h00;
  localparam logic [7:0] ADDR_SCALE_MIN = 8'h04;
  localparam logic [7:0] ADDR_SCALE_MAX = 8'h08;
  localparam logic [7:0] ADDR_RELAY_CFG = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;

  // Field positions
  localparam int POS_RANGE     = 0;
  localparam int POS_QUANT     = 4;
  localparam int POS_FUNC1     = 0;
  localparam int POS_FUNC2     = 8;
  localparam int POS_FUNC3     = 16;
  localparam int POS_NC1       = 24;
  localparam int POS_NC2       = 25;
  localparam int POS_ST_REL1   = 0;
  localparam int POS_ST_REL2   = 1;
  localparam int POS_ST_CO     = 2;
  localparam int POS_ST_HOLD   = 3;
  localparam int POS_ST_CODE   = 16;

  // Limits and reset values
  localparam logic [8:0] SCALE_LIMIT   = 9'h1F4;
  localparam logic [8:0] RST_SCALE_MIN = 9'h000;
  localparam logic [8:0] RST_SCALE_MAX = 9'h064;
  localparam logic [4:0] FUNC_LIMIT    = 5'h13;

  typedef enum logic [2:0] {
    RANGE_OFF      = 3'b000,
    RANGE_FULL     = 3'b001,
    RANGE_LIVE     = 3'b010,
    RANGE_FULL_INV = 3'b011,
    RANGE_LIVE_INV = 3'b100
  } oss_range_e;

  typedef enum logic [2:0] {
    QTY_CURRENT = 3'b001,
    QTY_VOLTAGE = 3'b010,
    QTY_POWER   = 3'b011,
    QTY_TORQUE  = 3'b100
  } oss_qty_e;

  typedef enum logic [4:0] {
    FN_OFF         = 5'h00,
    FN_OPERATION   = 5'h01,
    FN_FULL_VOLT   = 5'h02,
    FN_PWR_PRE     = 5'h03,
    FN_BRAKE       = 5'h04,
    FN_RUN         = 5'h05,
    FN_PWR_ALARM   = 5'h0A,
    FN_MAX_ALARM   = 5'h0B,
    FN_MAX_PRE     = 5'h0C,
    FN_MIN_ALARM   = 5'h0D,
    FN_MIN_PRE     = 5'h0E,
    FN_ALL_NO_PRE  = 5'h0F,
    FN_ALL_NO_PWR  = 5'h10,
    FN_EXT_ALARM   = 5'h11,
    FN_AR_EXPIRED  = 5'h12,
    FN_MANUAL      = 5'h13
  } oss_func_e;

  localparam oss_range_e RST_RANGE = RANGE_OFF;
  localparam oss_qty_e   RST_QTY   = QTY_CURRENT;
  localparam oss_func_e  RST_FUNC1 = FN_OPERATION;
  localparam oss_func_e  RST_FUNC2 = FN_FULL_VOLT;
  localparam oss_func_e  RST_FUNC3 = FN_ALL_NO_PRE;

  typedef struct packed {
    logic starting;
    logic full_volt;
    logic stopping;
    logic braking;
  } oss_phase_s;

  typedef struct packed {
    logic max_pwr_alarm;
    logic max_pwr_pre;
    logic min_pwr_alarm;
    logic min_pwr_pre;
    logic ext_alarm;
    logic other_alarm;
    logic ar_expired;
    logic manual_reset;
  } oss_alarm_s;

endpackage

// ### rtl/oss_output_selector.sv
// Output selector of a motor soft starter: one scaled analogue output
// code and three programmable relays, configured over AXI4-Lite.
// Assumes phase and alarm inputs come from logic on aclk.
//
// What this block does
// - Range off disables output; 1 is zero-based, 2 live-zero at 20 percent.
// - Ranges 3 and 4 invert ranges 1 and 2.
// - Quantity select, default 1: current, voltage, power, torque.
// - Quantity and scaling limits writable only while range is 1 to 4.
// - Changing quantity forces min limit 0 and max limit 100 percent.
// - Default scaling spans 0 to 100 percent of nominal.
// - Min limit 0 to 500 percent, default 0, marks range low end.
// - Max limit 0 to 500 percent, default 100, marks range high end.
// - Three relays, each with its own function select.
// - First two relays have polarity; third is a changeover relay.
// - Function 1 active during start, full voltage and stop.
// - Function 2 active only at full voltage.
// - Function 5 active in start and full voltage, not braking.
// - Function 4 active in braking, only 500 ms after run drops.
// - Function 3 follows either power pre-alarm.
// - Function 10 follows either power alarm.
// - Functions 11 to 14 each follow exactly one power condition.
// - Function 15 follows any alarm except power pre-alarms.
// - Function 16 excludes power alarms and power pre-alarms.
// - Function 17 follows only the external alarm.
// - Function 18 follows fault after auto reset attempts exhausted.
// - Function 19 follows every alarm needing manual reset.
// - Polarity 1 closes on activation, 2 opens; default 1.
// - Function off leaves contact set by polarity alone.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns

module oss_output_selector
  import oss_pkg::*;
#(
  parameter int DAC_W       = 12,
  parameter int MEAS_W      = 10,
  parameter int BRAKE_DELAY = BRAKE_DELAY_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [MEAS_W-1:0] meas_current,
  input  wire logic [MEAS_W-1:0] meas_voltage,
  input  wire logic [MEAS_W-1:0] meas_power,
  input  wire logic [MEAS_W-1:0] meas_torque,
  input  wire oss_phase_s        phase,
  input  wire oss_alarm_s        alarm,
  output logic [DAC_W-1:0]       aout_code,
  output logic                   aout_enable,
  output logic                   first_relay,
  output logic                   second_relay,
  output logic                   changeover_relay_no,
  output logic                   changeover_relay_nc
);

  // Status field holds at most 16 code bits; 500 percent needs 9 bits
  if (DAC_W < 4 || DAC_W > 16) begin : g_dac_chk
    $error("DAC_W must be 4 to 16");
  end
  if (MEAS_W < 9 || MEAS_W > 16) begin : g_meas_chk
    $error("MEAS_W must be 9 to 16");
  end
  if (BRAKE_DELAY < 1) begin : g_brake_chk
    $error("BRAKE_DELAY must be at least 1");
  end

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Relay coil decode, shared by all three relays
  function automatic logic relay_act(input logic [4:0] fn,
                                     input oss_phase_s ph,
                                     input oss_alarm_s al,
                                     input logic       brake_ok);
    logic pwr_alarm;
    logic pwr_pre;
    logic any_other;
    logic a;
    pwr_alarm = al.max_pwr_alarm | al.min_pwr_alarm;
    pwr_pre   = al.max_pwr_pre | al.min_pwr_pre;
    any_other = al.ext_alarm | al.other_alarm;
    case (fn)
      FN_OPERATION:  a = ph.starting | ph.full_volt | ph.stopping;
      FN_FULL_VOLT:  a = ph.full_volt;
      FN_RUN:        a = (ph.starting | ph.full_volt) & ~ph.braking;
      FN_BRAKE:      a = ph.braking & brake_ok;
      FN_PWR_PRE:    a = pwr_pre;
      FN_PWR_ALARM:  a = pwr_alarm;
      FN_MAX_ALARM:  a = al.max_pwr_alarm;
      FN_MAX_PRE:    a = al.max_pwr_pre;
      FN_MIN_ALARM:  a = al.min_pwr_alarm;
      FN_MIN_PRE:    a = al.min_pwr_pre;
      FN_ALL_NO_PRE: a = pwr_alarm | any_other;
      FN_ALL_NO_PWR: a = any_other;
      FN_EXT_ALARM:  a = al.ext_alarm;
      FN_AR_EXPIRED: a = al.ar_expired;
      FN_MANUAL:     a = al.manual_reset;
      // Direction functions 6 to 9 belong to a block not built here
      default:       a = 1'b0;
    endcase
    return a;
  endfunction

  // Configuration registers
  oss_range_e  range_q;
  oss_qty_e    qty_q;
  logic [8:0]  smin_q;
  logic [8:0]  smax_q;
  logic [4:0]  func_q [3];
  logic [1:0]  nc_q;

  // AXI write and read side
  logic        aw_hold_q;
  logic [7:0]  aw_addr_q;
  logic        w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire do_wr  = aw_hold_q & w_hold_q & ~bvalid_q;
  wire do_rd  = s_axi_arvalid & ~rvalid_q;
  wire wr_cfg = do_wr & (aw_addr_q == ADDR_AOUT_CFG);
  wire wr_min = do_wr & (aw_addr_q == ADDR_SCALE_MIN);
  wire wr_max = do_wr & (aw_addr_q == ADDR_SCALE_MAX);
  wire wr_rel = do_wr & (aw_addr_q == ADDR_RELAY_CFG);
  wire wr_ok  = wr_cfg | wr_min | wr_max | wr_rel;

  // Current register images, used for reads and byte merges
  logic [31:0] cfg_img;
  logic [31:0] min_img;
  logic [31:0] max_img;
  logic [31:0] rel_img;
  logic [31:0] st_img;
  assign cfg_img = {25'h000_0000, qty_q, 1'b0, range_q};
  assign min_img = {23'h00_0000, smin_q};
  assign max_img = {23'h00_0000, smax_q};
  assign rel_img = {6'h00, nc_q, 3'h0, func_q[2], 3'h0, func_q[1], 3'h0, func_q[0]};

  wire [31:0] cfg_new = merge(cfg_img, w_data_q, w_strb_q);
  wire [31:0] min_new = merge(min_img, w_data_q, w_strb_q);
  wire [31:0] max_new = merge(max_img, w_data_q, w_strb_q);
  wire [31:0] rel_new = merge(rel_img, w_data_q, w_strb_q);

  wire [2:0] new_range = cfg_new[POS_RANGE +: 3];
  wire [2:0] new_qty   = cfg_new[POS_QUANT +: 3];
  wire       aout_on   = (range_q != RANGE_OFF);
  wire       range_ok  = (new_range <= RANGE_LIVE_INV);
  wire       qty_ok    = (new_qty >= QTY_CURRENT) && (new_qty <= QTY_TORQUE);
  // Locked settings are kept silently; the write still completes OKAY
  wire       qty_wr    = wr_cfg & aout_on & qty_ok;
  wire       qty_chg   = qty_wr & (new_qty != qty_q);
  wire       min_wr    = wr_min & aout_on & (min_new[8:0] <= SCALE_LIMIT);
  wire       max_wr    = wr_max & aout_on & (max_new[8:0] <= SCALE_LIMIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Analogue configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_q <= RST_RANGE;
      qty_q   <= RST_QTY;
      smin_q  <= RST_SCALE_MIN;
      smax_q  <= RST_SCALE_MAX;
    end else begin
      if (wr_cfg & range_ok) begin
        range_q <= oss_range_e'(new_range);
      end
      if (qty_wr) begin
        qty_q <= oss_qty_e'(new_qty);
      end
      if (qty_chg) begin
        smin_q <= RST_SCALE_MIN;
        smax_q <= RST_SCALE_MAX;
      end else begin
        if (min_wr) begin
          smin_q <= min_new[8:0];
        end
        if (max_wr) begin
          smax_q <= max_new[8:0];
        end
      end
    end
  end

  // Relay configuration; out-of-range function codes leave a field alone
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_func
      wire [4:0] fn_new = rel_new[8*g +: 5];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          func_q[g] <= (g == 0) ? RST_FUNC1 : (g == 1) ? RST_FUNC2 : RST_FUNC3;
        end else if (wr_rel && fn_new <= FUNC_LIMIT) begin
          func_q[g] <= fn_new;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nc_q <= 2'b00;
    end else if (wr_rel) begin
      nc_q <= {rel_new[POS_NC2], rel_new[POS_NC1]};
    end
  end

  // Brake holdoff: reloads while run is asserted, counts down after
  logic [31:0] hold_cnt_q;
  wire         run_cond = phase.starting | phase.full_volt;
  wire         brake_ok = (hold_cnt_q == 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_q <= 32'h0000_0000;
    end else if (run_cond) begin
      hold_cnt_q <= 32'(BRAKE_DELAY);
    end else if (!brake_ok) begin
      hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
    end
  end

  // Relay coils and contacts
  wire act1 = relay_act(func_q[0], phase, alarm, brake_ok);
  wire act2 = relay_act(func_q[1], phase, alarm, brake_ok);
  wire act3 = relay_act(func_q[2], phase, alarm, brake_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_relay         <= 1'b0;
      second_relay        <= 1'b0;
      changeover_relay_no <= 1'b0;
      changeover_relay_nc <= 1'b1;
    end else begin
      // Off gives act of zero, so polarity alone sets the contact
      first_relay         <= act1 ^ nc_q[0];
      second_relay        <= act2 ^ nc_q[1];
      changeover_relay_no <= act3;
      changeover_relay_nc <= ~act3;
    end
  end

  // Analogue scaling
  localparam logic [31:0] FS   = 32'((1 << DAC_W) - 1);
  localparam logic [31:0] LIVE = 32'(((1 << DAC_W) - 1) / 5);

  logic [MEAS_W-1:0] meas_sel;
  always_comb begin
    case (qty_q)
      QTY_VOLTAGE: meas_sel = meas_voltage;
      QTY_POWER:   meas_sel = meas_power;
      QTY_TORQUE:  meas_sel = meas_torque;
      default:     meas_sel = meas_current;
    endcase
  end

  wire        is_live = (range_q == RANGE_LIVE) || (range_q == RANGE_LIVE_INV);
  wire        is_inv  = (range_q == RANGE_FULL_INV) || (range_q == RANGE_LIVE_INV);
  wire [31:0] base    = is_live ? LIVE : 32'h0000_0000;
  wire [31:0] span    = FS - base;
  wire [31:0] v32     = 32'(meas_sel);
  wire [31:0] mn32    = 32'(smin_q);
  wire [31:0] mx32    = 32'(smax_q);
  wire [31:0] den     = mx32 - mn32;
  // Divider is combinational; at 10 MHz the period leaves ample slack
  wire [31:0] lin     = ((v32 - mn32) * span) / ((den == 32'h0000_0000) ? 32'h0000_0001 : den);
  wire [31:0] frac    = (v32 <= mn32) ? 32'h0000_0000 :
                        (v32 >= mx32) ? span : lin;
  wire [31:0] level   = is_inv ? (FS - frac) : (base + frac);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aout_code   <= '0;
      aout_enable <= 1'b0;
    end else begin
      aout_code   <= aout_on ? level[DAC_W-1:0] : '0;
      aout_enable <= aout_on;
    end
  end

  // Status and read path
  wire hold_pend = ~brake_ok & phase.braking;
  // Code sits from bit 16 up, so a 12-bit code fills bits 27 to 16
  assign st_img = {16'(aout_code), 12'h000, hold_pend, changeover_relay_no,
                   second_relay, first_relay};

  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (rd_addr)
      ADDR_AOUT_CFG:  rd_val = cfg_img;
      ADDR_SCALE_MIN: rd_val = min_img;
      ADDR_SCALE_MAX: rd_val = max_img;
      ADDR_RELAY_CFG: rd_val = rel_img;
      ADDR_STATUS:    rd_val = st_img;
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (do_rd) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ### tb/oss_output_selector_properties.sv
// Concurrent checks on the output selector's ports.
// Assumes full-strobe, legal relay setting writes, as the bench makes.
`timescale 1ns/1ns

module oss_output_selector_props
  import oss_pkg::*;
#(
  parameter int BRAKE_DELAY = BRAKE_DELAY_CYC
) (
  input logic        aclk,
  input logic        aresetn,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input oss_phase_s  phase,
  input oss_alarm_s  alarm,
  input logic        first_relay,
  input logic        second_relay,
  input logic        changeover_relay_no,
  input logic        changeover_relay_nc
);
  logic [31:0] cfg_q;
  logic [1:0]  age_q;
  int          gap_q;
  wire aw_ok = s_axi_awvalid && s_axi_awready;
  wire w_ok = s_axi_wvalid && s_axi_wready;
  wire cfg_wr = aw_ok && w_ok && s_axi_awaddr == ADDR_RELAY_CFG;
  wire run = phase.starting | phase.full_volt;
  wire settled = age_q == 2'h3;

  // Mirror leads the design by one edge, so relations wait until it settles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= 32'h000F_0201;
      age_q <= 2'h3;
      gap_q <= BRAKE_DELAY + 1;
    end else begin
      if (cfg_wr) cfg_q <= s_axi_wdata;
      age_q <= cfg_wr ? 2'h0 : (settled ? age_q : age_q + 2'h1);
      gap_q <= run ? 0 : (gap_q > BRAKE_DELAY ? gap_q : gap_q + 1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    aw_ok && w_ok;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_co_complement: assert property (
    changeover_relay_no != changeover_relay_nc) else $error("changeover contacts equal");
  a_operation_relay: assert property (
    settled && cfg_q[4:0] == FN_OPERATION && !cfg_q[24] && $past(aresetn) |->
    first_relay == $past(run | phase.stopping)) else $error("operation relay wrong");
  a_full_volt_relay: assert property (
    settled && cfg_q[12:8] == FN_FULL_VOLT && !cfg_q[25] && $past(aresetn) |->
    second_relay == $past(phase.full_volt)) else $error("full voltage relay wrong");
  a_alarm_relay: assert property (
    settled && cfg_q[20:16] == FN_ALL_NO_PRE && $past(aresetn) |-> changeover_relay_no ==
    $past(alarm.max_pwr_alarm | alarm.min_pwr_alarm | alarm.ext_alarm | alarm.other_alarm))
    else $error("all alarms relay wrong");
  a_brake_holdoff: assert property (
    settled && cfg_q[12:8] == FN_BRAKE && !cfg_q[25] && second_relay |-> gap_q > BRAKE_DELAY)
    else $error("brake relay too early");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
  a_read_answer: assert property (
    s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (
    s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule

bind oss_output_selector oss_output_selector_props #(.BRAKE_DELAY(BRAKE_DELAY)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .phase(phase), .alarm(alarm), .first_relay(first_relay), .second_relay(second_relay),
  .changeover_relay_no(changeover_relay_no), .changeover_relay_nc(changeover_relay_nc));

// ### tb/oss_contactor_model.sv
// Run and brake contactor pair on the first two relays.
// Assumes the run coil on one relay and the brake coil on the other.
`timescale 1ns/1ns

module oss_contactor_model #(
  parameter int MIN_GAP = 20
) (
  input  logic aclk,
  input  logic aresetn,
  input  logic run_coil,
  input  logic brake_coil,
  output logic clash
);
  int gap;
  // Phase short if the brake pulls in before the run arc has cleared
  always @(negedge aclk) begin
    if (!aresetn) begin
      clash = 1'b0;
      gap = MIN_GAP;
    end else begin
      if (run_coil) gap = 0;
      else if (gap < MIN_GAP) gap = gap + 1;
      if (brake_coil && gap < MIN_GAP) clash = 1'b1;
    end
  end
endmodule

// ### tb/oss_output_selector_bench.sv
// Self-checking bench for the output selector over AXI4-Lite.
// Assumes oss_pkg, the checker and the contactor model are compiled first.
`timescale 1ns/1ns

module oss_output_selector_bench;
  import oss_pkg::*;
  logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic        en, r1, r2, cno, cnc, clash;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  logic [9:0]  mi, mu, mp, mt;
  logic [11:0] code;
  oss_phase_s  ph;
  oss_alarm_s  al;
  int          err_count, n_checks;
  int          pts[3] = '{20, 100, 600};

  oss_output_selector #(.BRAKE_DELAY(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .meas_current(mi),
    .meas_voltage(mu), .meas_power(mp), .meas_torque(mt), .phase(ph), .alarm(al),
    .aout_code(code), .aout_enable(en), .first_relay(r1), .second_relay(r2),
    .changeover_relay_no(cno), .changeover_relay_nc(cnc));
  oss_contactor_model #(.MIN_GAP(20)) mdl (
    .aclk(aclk), .aresetn(aresetn), .run_coil(r1), .brake_coil(r2), .clash(clash));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return awr;
      1: return wr;
      2: return bv;
      3: return arr;
      default: return rv;
    endcase
  endfunction
  task automatic await(input int s);
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (sig(s) !== 1'b1 && n < 50);
    if (sig(s) !== 1'b1) begin
      err_count++;
      end_sim;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    await(0);
    if (wr !== 1'b1) begin
      @(posedge aclk); awv <= 1'b0;
      await(1);
    end
    @(posedge aclk); awv <= 1'b0; wv <= 1'b0;
    await(2);
    check("bresp", bresp, e);
    @(posedge aclk); br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk); ara <= a; arv <= 1'b1; rr <= 1'b1;
    await(3);
    @(posedge aclk); arv <= 1'b0;
    await(4);
    check("rdata", rd, e);
    check("rresp", rresp, er);
    @(posedge aclk); rr <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge aclk); aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Relay one takes function f and polarity nc; others are switched off
  task automatic rel(input logic [4:0] f, input logic [7:0] a, input logic nc, input logic e);
    axi_wr(ADDR_RELAY_CFG, {7'h00, nc, 19'h0_0000, f}, 2'h0);
    @(posedge aclk); al <= oss_alarm_s'(a);
    tick(3);
    check("first_relay", r1, e);
  endtask
  task automatic ph_case(input logic [3:0] p, input logic e1, input logic e2);
    @(posedge aclk); ph <= oss_phase_s'(p);
    tick(3);
    check("first_relay", r1, e1);
    check("second_relay", r2, e2);
  endtask
  function automatic logic [11:0] exp_code(input int r, input int v, input int lo, input int hi);
    int base, span, f;
    base = (r == 2 || r == 4) ? 819 : 0;
    span = 4095 - base;
    f = v <= lo ? 0 : v >= hi ? span : (v - lo) * span / (hi - lo);
    return 12'((r >= 3) ? 4095 - f : base + f);
  endfunction

  initial begin
    {awv, wv, br, arv, rr} = 5'h00; awa = 8'h00; ara = 8'h00; wd = 32'h0000_0000;
    ph = 4'h0; al = 8'h00; mi = 10'h000; mu = 10'h000; mp = 10'h000; mt = 10'h000;
    err_count = 0; n_checks = 0; aresetn = 1'b0;
    do_reset;
    axi_rd(ADDR_AOUT_CFG, 32'h0000_0010, 2'h0);
    axi_rd(ADDR_SCALE_MIN, 32'h0000_0000, 2'h0);
    axi_rd(ADDR_SCALE_MAX, 32'h0000_0064, 2'h0);
    axi_rd(ADDR_RELAY_CFG, 32'h000F_0201, 2'h0);
    axi_rd(8'h14, 32'h0000_0000, 2'h2);
    axi_wr(ADDR_STATUS, 32'h0000_0001, 2'h2);
    check("aout_enable", en, 1'b0);
    axi_wr(ADDR_SCALE_MIN, 32'h0000_0032, 2'h0);
    axi_rd(ADDR_SCALE_MIN, 32'h0000_0000, 2'h0);
    @(posedge aclk); mi <= 10'h019; mu <= 10'h032; mp <= 10'h04B; mt <= 10'h064;
    for (int r = 1; r <= 4; r++)
      for (int q = 1; q <= 4; q++) begin
        axi_wr(ADDR_AOUT_CFG, 32'(q * 16 + r), 2'h0);
        tick(3);
        check("aout_code", code, exp_code(r, q * 25, 0, 100));
      end
    check("aout_enable", en, 1'b1);
    axi_rd(ADDR_STATUS, 32'h0333_0000, 2'h0);
    axi_wr(ADDR_AOUT_CFG, 32'h0000_0011, 2'h0);
    axi_wr(ADDR_SCALE_MIN, 32'h0000_0032, 2'h0);
    axi_wr(ADDR_SCALE_MAX, 32'h0000_01F4, 2'h0);
    axi_wr(ADDR_SCALE_MAX, 32'h0000_01F5, 2'h0);
    axi_rd(ADDR_SCALE_MAX, 32'h0000_01F4, 2'h0);
    foreach (pts[i]) begin
      @(posedge aclk); mi <= 10'(pts[i]);
      tick(3);
      check("aout_code", code, exp_code(1, pts[i], 50, 500));
    end
    axi_wr(ADDR_AOUT_CFG, 32'h0000_0021, 2'h0);
    axi_rd(ADDR_SCALE_MIN, 32'h0000_0000, 2'h0);
    axi_rd(ADDR_SCALE_MAX, 32'h0000_0064, 2'h0);
    ph_case(4'h8, 1'b1, 1'b0);
    ph_case(4'h4, 1'b1, 1'b1);
    ph_case(4'h2, 1'b1, 1'b0);
    ph_case(4'h0, 1'b0, 1'b0);
    @(posedge aclk); al <= 8'h08;
    tick(3);
    check("changeover_no", cno, 1'b1);
    check("changeover_nc", cnc, 1'b0);
    rel(FN_PWR_PRE, 8'h10, 1'b0, 1'b1);
    rel(FN_PWR_PRE, 8'hA0, 1'b0, 1'b0);
    rel(FN_PWR_ALARM, 8'h20, 1'b0, 1'b1);
    rel(FN_PWR_ALARM, 8'h50, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rel(5'(11 + k), 8'h80 >> k, 1'b0, 1'b1);
      rel(5'(11 + k), ~(8'h80 >> k), 1'b0, 1'b0);
    end
    rel(FN_ALL_NO_PRE, 8'h04, 1'b0, 1'b1);
    rel(FN_ALL_NO_PRE, 8'h50, 1'b0, 1'b0);
    rel(FN_ALL_NO_PWR, 8'hA0, 1'b0, 1'b0);
    rel(FN_ALL_NO_PWR, 8'h04, 1'b0, 1'b1);
    rel(FN_EXT_ALARM, 8'h04, 1'b0, 1'b0);
    rel(FN_EXT_ALARM, 8'h08, 1'b0, 1'b1);
    rel(FN_AR_EXPIRED, 8'h02, 1'b0, 1'b1);
    rel(FN_AR_EXPIRED, 8'h00, 1'b0, 1'b0);
    rel(FN_MANUAL, 8'h01, 1'b0, 1'b1);
    rel(FN_EXT_ALARM, 8'h08, 1'b1, 1'b0);
    rel(FN_EXT_ALARM, 8'h00, 1'b1, 1'b1);
    rel(FN_OFF, 8'hFF, 1'b1, 1'b1);
    rel(FN_OFF, 8'hFF, 1'b0, 1'b0);
    do_reset;
    axi_rd(ADDR_RELAY_CFG, 32'h000F_0201, 2'h0);
    axi_wr(ADDR_RELAY_CFG, 32'h0000_0405, 2'h0);
    ph_case(4'h8, 1'b1, 1'b0);
    ph_case(4'h3, 1'b0, 1'b0);
    tick(16);
    check("second_relay", r2, 1'b0);
    tick(4);
    check("second_relay", r2, 1'b1);
    check("contactor clash", clash, 1'b0);
    axi_rd(ADDR_STATUS, 32'h0000_0002, 2'h0);
    end_sim;
  end
endmodule
